// ==== mcx_core.sv ====
// Execute stage for moves, bit ops, branches, skips and table reads
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
module mcx_core #(
	parameter int STACK_DEPTH = mcx_pkg::STACK_DEPTH_DEF
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire mcx_pkg::mcx_instr_t instr,
	input wire logic instr_valid,
	output logic instr_ready,
	output logic [mcx_pkg::PC_W-1:0] pc,
	output logic [mcx_pkg::PC_W-1:0] pm_addr,
	input wire logic [mcx_pkg::PM_W-1:0] pm_data,
	input wire logic wdt_timeout,
	input wire logic wake,
	output logic wdt_restart,
	output logic power_down,
	output logic int_enable,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import mcx_pkg::*;

	typedef enum {st_idle, st_stall, st_table, st_halt} mcx_state_t;

	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction

	mcx_state_t state;
	logic [7:0] dmem [2**DM_AW];
	logic [PC_W-1:0] stack [STACK_DEPTH];
	logic [$clog2(STACK_DEPTH)-1:0] sp;
	logic [7:0] working_register;
	logic [7:0] table_pointer_register;
	logic [PM_W-9:0] table_high_byte_register;
	logic [7:0] table_page;
	logic watchdog_timeout_flag;
	logic power_down_flag;
	logic [1:0] stall_cnt;
	logic [DM_AW-1:0] table_dest;
	logic run;
	logic bus_ack;

	mcx_op_t op;
	logic take;
	logic [7:0] mem_val;
	logic [7:0] mask;
	logic [7:0] inc_val;
	logic [7:0] dec_val;
	logic [7:0] swap_val;
	logic [7:0] step_val;
	logic op_wr;
	logic [7:0] op_wr_data;
	logic acc_wr;
	logic [7:0] acc_data;
	logic skip;
	logic is_branch;
	logic is_exit;
	logic is_table;
	logic tbl_adv;
	logic tbl_last;
	logic [7:0] tbl_ptr_use;
	logic [PC_W-1:0] tbl_addr;
	logic wr_en;
	logic [DM_AW-1:0] wr_addr;
	logic [7:0] wr_data;
	logic pcl_hit;
	logic wr_special;
	logic [PC_W-1:0] pc_seq;
	logic [PC_W-1:0] pc_pop;
	logic [PC_W-1:0] pc_take;
	logic [PC_W-1:0] pc_base;
	logic [PC_W-1:0] next_pc;
	logic [1:0] n_cyc;
	logic to_set;
	logic bus_wr;
	logic [31:0] rd_mux;

	assign op = instr.op;
	assign instr_ready = (state == st_idle) && run;
	assign take = clk_en && instr_valid && instr_ready;
	assign power_down = (state == st_halt);

	// Sector zero only: the address field is as wide as one sector
	assign mem_val = (instr.mem_addr == ADDR_PCL) ? pc[7:0] :
		(instr.mem_addr == ADDR_TABLE_POINTER_REGISTER) ? table_pointer_register :
		(instr.mem_addr == ADDR_TABLE_HIGH_BYTE_REGISTER) ? table_high_byte_register :
		(instr.mem_addr == ADDR_TBPAGE) ? table_page :
		(instr.mem_addr == ADDR_STATUS) ?
		{6'h00, power_down_flag, watchdog_timeout_flag} :
		dmem[instr.mem_addr];

	assign mask = bit_mask(instr.bit_sel);
	assign inc_val = mem_val + 8'h01;
	assign dec_val = mem_val - 8'h01;
	assign swap_val = {mem_val[3:0], mem_val[7:4]};
	assign step_val = (op inside {op_increment_skip_zero,
		op_increment_skip_zero_to_working}) ? inc_val : dec_val;

	// Memory results of ops that write at issue
	assign op_wr = op inside {op_transfer_byte_to_memory, op_bit_clear,
		op_bit_set, op_increment_skip_zero, op_decrement_skip_zero,
		op_byte_clear, op_byte_set, op_nibble_exchange};
	assign op_wr_data =
		(op == op_transfer_byte_to_memory) ? working_register :
		(op == op_bit_clear) ? (mem_val & ~mask) :
		(op == op_bit_set) ? (mem_val | mask) :
		(op == op_byte_clear) ? 8'h00 :
		(op == op_byte_set) ? 8'hff :
		(op == op_nibble_exchange) ? swap_val :
		step_val;

	// Working register results
	assign acc_wr = op inside {op_transfer_byte_to_working,
		op_skip_zero_copy_to_working, op_load_immediate,
		op_subroutine_exit_load, op_increment_skip_zero_to_working,
		op_decrement_skip_zero_to_working, op_nibble_exchange_to_working};
	assign acc_data = (op inside {op_transfer_byte_to_working,
		op_skip_zero_copy_to_working}) ? mem_val :
		(op inside {op_load_immediate,
		op_subroutine_exit_load}) ? instr.imm :
		(op == op_nibble_exchange_to_working) ? swap_val :
		step_val;

	assign skip = (op inside {op_skip_when_byte_zero,
		op_skip_zero_copy_to_working}) ? (mem_val == 8'h00) :
		(op == op_skip_when_nonzero) ? (mem_val != 8'h00) :
		(op == op_skip_bit_zero) ? ((mem_val & mask) == 8'h00) :
		(op == op_skip_bit_nonzero) ? ((mem_val & mask) != 8'h00) :
		(op inside {op_increment_skip_zero, op_decrement_skip_zero,
		op_increment_skip_zero_to_working,
		op_decrement_skip_zero_to_working}) ?
		(step_val == 8'h00) : 1'b0;

	assign is_branch = op inside {op_unconditional_branch,
		op_subroutine_call};
	assign is_exit = op inside {op_subroutine_exit, op_subroutine_exit_load,
		op_interrupt_exit};
	assign is_table = op inside {op_table_fetch_page,
		op_table_fetch_last_page, op_pointer_advance_table_fetch,
		op_pointer_advance_last_page_fetch};
	assign tbl_adv = op inside {op_pointer_advance_table_fetch,
		op_pointer_advance_last_page_fetch};
	assign tbl_last = op inside {op_table_fetch_last_page,
		op_pointer_advance_last_page_fetch};

	// Table address built from the pointer after any advance
	assign tbl_ptr_use = tbl_adv ? table_pointer_register + 8'h01 :
		table_pointer_register;
	assign tbl_addr = tbl_last ? {LAST_PAGE, tbl_ptr_use} :
		{table_page[PC_W-9:0], tbl_ptr_use};

	// One memory write port shared by ops writing at issue and table landing
	assign wr_en = (take && op_wr) || (clk_en && state == st_table);
	assign wr_addr = (state == st_table) ? table_dest : instr.mem_addr;
	assign wr_data = (state == st_table) ? pm_data[7:0] : op_wr_data;
	assign pcl_hit = wr_en && (wr_addr == ADDR_PCL);
	assign wr_special = wr_addr inside {ADDR_PCL, ADDR_TABLE_POINTER_REGISTER, ADDR_TABLE_HIGH_BYTE_REGISTER,
		ADDR_TBPAGE, ADDR_STATUS};

	assign pc_seq = pc + (skip ? PC_W'(2) : PC_W'(1));
	assign pc_pop = stack[sp - 1'b1];
	assign pc_take = is_branch ? instr.target : is_exit ? pc_pop : pc_seq;
	assign pc_base = (state == st_table) ? pc : pc_take;
	assign next_pc = pcl_hit ? {pc_base[PC_W-1:8], wr_data} : pc_base;

	assign n_cyc = (is_branch || is_exit || pcl_hit) ? CYC_BRANCH :
		skip ? CYC_SKIP : 2'h1;

	// Timeout arriving with a clear wins over the clear
	assign to_set = clk_en && wdt_timeout;

	// Sequencing
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= st_idle;
			stall_cnt <= 2'h0;
		end else if (clk_en) begin
			unique case (state)
				st_idle: begin
					if (take && op == op_power_down) begin
						state <= st_halt;
					end else if (take && is_table) begin
						state <= st_table;
					end else if (take && n_cyc != 2'h1) begin
						state <= st_stall;
						stall_cnt <= n_cyc - 2'h2;
					end
				end
				st_stall: begin
					if (stall_cnt == 2'h0) begin
						state <= st_idle;
					end else begin
						stall_cnt <= stall_cnt - 2'h1;
					end
				end
				st_table: begin
					state <= st_idle;
				end
				st_halt: begin
					if (wake) begin
						state <= st_idle;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pc <= PC_RESET;
		end else if (take || (clk_en && state == st_table)) begin
			pc <= next_pc;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sp <= '0;
		end else if (take && op == op_subroutine_call) begin
			sp <= sp + 1'b1;
		end else if (take && is_exit) begin
			sp <= sp - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (take && op == op_subroutine_call) begin
			stack[sp] <= pc + PC_W'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (wr_en && !wr_special) begin
			dmem[wr_addr] <= wr_data;
		end
	end

	// Table fetch: address out at issue, word lands one cycle later
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pm_addr <= PC_RESET;
			table_dest <= '0;
		end else if (take && is_table) begin
			pm_addr <= tbl_addr;
			table_dest <= instr.mem_addr;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			table_pointer_register <= 8'h00;
			table_page <= 8'h00;
			table_high_byte_register <= '0;
		end else begin
			if (take && is_table && tbl_adv) begin
				table_pointer_register <= tbl_ptr_use;
			end else if (wr_en && wr_addr == ADDR_TABLE_POINTER_REGISTER) begin
				table_pointer_register <= wr_data;
			end
			if (wr_en && wr_addr == ADDR_TBPAGE) begin
				table_page <= wr_data;
			end
			if (clk_en && state == st_table) begin
				table_high_byte_register <= pm_data[PM_W-1:8];
			end else if (wr_en && wr_addr == ADDR_TABLE_HIGH_BYTE_REGISTER) begin
				table_high_byte_register <= wr_data;
			end
		end
	end

	// Bus write lands after the core so software has the last word
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			working_register <= 8'h00;
		end else if (bus_wr && avs_address == REG_WORKING) begin
			working_register <= avs_writedata[7:0];
		end else if (take && acc_wr) begin
			working_register <= acc_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			watchdog_timeout_flag <= 1'b0;
			power_down_flag <= 1'b0;
			wdt_restart <= 1'b0;
		end else begin
			if (clk_en) begin
				wdt_restart <= take && (op inside {op_watchdog_clear,
					op_power_down});
			end
			if (to_set) begin
				watchdog_timeout_flag <= 1'b1;
			end else if (take && (op inside {op_watchdog_clear,
				op_power_down})) begin
				watchdog_timeout_flag <= 1'b0;
			end
			if (take && op == op_watchdog_clear) begin
				power_down_flag <= 1'b0;
			end else if (take && op == op_power_down) begin
				power_down_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			run <= RUN_RESET;
			int_enable <= 1'b0;
		end else if (bus_wr && avs_address == REG_CTRL) begin
			run <= avs_writedata[CTRL_RUN];
			int_enable <= avs_writedata[CTRL_IE];
		end else if (take && op == op_interrupt_exit) begin
			int_enable <= 1'b1;
		end
	end

	// Avalon-MM slave: one wait state, read data captured with the ack
	assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
	assign bus_wr = clk_en && avs_write && bus_ack;
	assign rd_mux = (avs_address == REG_WORKING) ?
		{24'h00_0000, working_register} :
		(avs_address == REG_STATUS) ? {28'h000_0000, int_enable,
		power_down, power_down_flag, watchdog_timeout_flag} :
		(avs_address == REG_TABLE_POINTER_REGISTER) ? {24'h00_0000, table_pointer_register} :
		(avs_address == REG_TABLE_HIGH_BYTE_REGISTER) ?
		{24'h00_0000, table_high_byte_register} :
		(avs_address == REG_PC) ? {19'h0_0000, pc} :
		(avs_address == REG_CTRL) ? {30'h0000_0000, int_enable, run} :
		32'h0000_0000;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bus_ack <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			bus_ack <= (avs_read || avs_write) && !bus_ack;
			if (avs_read && !bus_ack) begin
				avs_readdata <= rd_mux;
			end
		end
	end
endmodule

// ==== mcx_pkg.sv ====
// Package: opcodes, carriers, register map and cycle counts of the core
package mcx_pkg;
	localparam int PC_W = 13;
	localparam int DM_AW = 8;
	localparam int PM_W = 16;
	localparam int STACK_DEPTH_DEF = 8;

	// Special locations inside data memory sector zero
	localparam logic [7:0] ADDR_PCL = 8'h06;
	localparam logic [7:0] ADDR_TABLE_POINTER_REGISTER = 8'h07;
	localparam logic [7:0] ADDR_TABLE_HIGH_BYTE_REGISTER = 8'h08;
	localparam logic [7:0] ADDR_TBPAGE = 8'h09;
	localparam logic [7:0] ADDR_STATUS = 8'h0a;

	// Avalon-MM byte offsets
	localparam logic [7:0] REG_WORKING = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TABLE_POINTER_REGISTER = 8'h08;
	localparam logic [7:0] REG_TABLE_HIGH_BYTE_REGISTER = 8'h0c;
	localparam logic [7:0] REG_PC = 8'h10;
	localparam logic [7:0] REG_CTRL = 8'h14;

	localparam int CTRL_RUN = 0;
	localparam int CTRL_IE = 1;
	localparam int ST_TO = 0;
	localparam int ST_PDF = 1;
	localparam int ST_HALT = 2;
	localparam int ST_IE = 3;

	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic RUN_RESET = 1'b1;
	localparam logic [PC_W-9:0] LAST_PAGE = '1;

	localparam logic [1:0] CYC_BRANCH = 2'h2;
	localparam logic [1:0] CYC_SKIP = 2'h3;
	localparam logic [1:0] CYC_TABLE = 2'h2;

	typedef enum logic [4:0] {
		op_no_operation,
		op_transfer_byte_to_working,
		op_transfer_byte_to_memory,
		op_load_immediate,
		op_bit_clear,
		op_bit_set,
		op_unconditional_branch,
		op_subroutine_call,
		op_subroutine_exit,
		op_subroutine_exit_load,
		op_interrupt_exit,
		op_skip_when_byte_zero,
		op_skip_zero_copy_to_working,
		op_skip_when_nonzero,
		op_skip_bit_zero,
		op_skip_bit_nonzero,
		op_increment_skip_zero,
		op_decrement_skip_zero,
		op_increment_skip_zero_to_working,
		op_decrement_skip_zero_to_working,
		op_table_fetch_page,
		op_table_fetch_last_page,
		op_pointer_advance_table_fetch,
		op_pointer_advance_last_page_fetch,
		op_byte_clear,
		op_byte_set,
		op_watchdog_clear,
		op_nibble_exchange,
		op_nibble_exchange_to_working,
		op_power_down
	} mcx_op_t;

	typedef struct packed {
		mcx_op_t op;
		logic [DM_AW-1:0] mem_addr;
		logic [2:0] bit_sel;
		logic [7:0] imm;
		logic [PC_W-1:0] target;
	} mcx_instr_t;
endpackage

// ==== mcx_core_monitor.sv ====
// Checker for cycle counts and control outputs of the execute core
`timescale 1ns/1ns
module mcx_core_monitor #(
	parameter int STACK_DEPTH = mcx_pkg::STACK_DEPTH_DEF
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire mcx_pkg::mcx_instr_t instr,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic [mcx_pkg::PC_W-1:0] pc,
	input wire logic [mcx_pkg::PC_W-1:0] pm_addr,
	input wire logic wdt_restart,
	input wire logic power_down
);
	import mcx_pkg::*;
	wire tk = clk_en && instr_valid && instr_ready;
	wire one_op = instr.op inside {op_no_operation, op_load_immediate};
	wire br_op = instr.op inside {[op_unconditional_branch:op_interrupt_exit]};
	wire jmp_op = instr.op inside {op_unconditional_branch, op_subroutine_call};
	wire sk_op = instr.op inside {
		[op_skip_when_byte_zero:op_decrement_skip_zero_to_working]};
	wire tb_op = instr.op inside {
		[op_table_fetch_page:op_pointer_advance_last_page_fetch]};
	wire lp_op = instr.op inside {
		op_table_fetch_last_page, op_pointer_advance_last_page_fetch};
	wire pcl_wr = instr.op == op_transfer_byte_to_memory
		&& instr.mem_addr == ADDR_PCL;
	wire wd_op = instr.op inside {op_watchdog_clear, op_power_down};
	// Stall checks assume clk_en stays high while an op is in flight
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	one_cycle_op_a: assert property (
		tk && one_op |=> instr_ready)
		else $error("single cycle op stalled");
	branch_two_cyc_a: assert property (
		tk && br_op |=> !instr_ready ##1 instr_ready)
		else $error("branch cycle count wrong");
	branch_target_a: assert property (
		tk && jmp_op |=> pc == $past(instr.target))
		else $error("branch target not loaded");
	pcl_write_two_a: assert property (
		tk && pcl_wr |=> !instr_ready ##1 instr_ready)
		else $error("pc low write cycle count wrong");
	skip_taken_cyc_a: assert property (
		tk && sk_op ##1 pc == $past(pc) + 13'd2
		|-> !instr_ready [*2] ##1 instr_ready)
		else $error("taken skip cycle count wrong");
	skip_pc_step_a: assert property (
		tk && sk_op |=> (instr_ready && pc == $past(pc) + 13'd1)
		|| pc == $past(pc) + 13'd2)
		else $error("skip pc step wrong");
	table_two_cyc_a: assert property (
		tk && tb_op |=> !instr_ready ##1 instr_ready)
		else $error("table fetch cycle count wrong");
	last_page_a: assert property (
		tk && lp_op |=> pm_addr[12:8] == LAST_PAGE)
		else $error("last page fetch address wrong");
	wdt_restart_a: assert property (
		tk && wd_op |=> wdt_restart)
		else $error("watchdog restart missing");
	pd_enter_a: assert property (
		tk && instr.op == op_power_down |=> power_down && !instr_ready)
		else $error("power down not entered");
endmodule

bind mcx_core mcx_core_monitor #(.STACK_DEPTH(STACK_DEPTH)) u_mon (
	.ref_clk, .rst, .clk_en, .instr, .instr_valid, .instr_ready,
	.pc, .pm_addr, .wdt_restart, .power_down);

// ==== mcx_core_tb.sv ====
// Self-checking bench for the execute core with a reference model
`timescale 1ns/1ns
module mcx_core_tb;
	import mcx_pkg::*;
	logic ref_clk, rst, clk_en, instr_valid, instr_ready;
	logic wdt_timeout, wake, wdt_restart, power_down, int_enable;
	logic avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [PC_W-1:0] pc, pm_addr, exp_pc;
	mcx_instr_t instr;
	logic [7:0] mem [256];
	logic [7:0] wreg;
	logic [1:0] flg;
	logic [PC_W-1:0] stk [$];
	int fails, cmp_count, c;
	int seed = 32'h0a82_f99e;

	// Word derived from address so each table fetch returns a distinct value
	function automatic logic [15:0] pm_word(input logic [12:0] ad);
		return {ad[12:5] ^ 8'h3c, ad[7:0] ^ 8'ha5};
	endfunction
	wire [PM_W-1:0] pm_data = pm_word(pm_addr);

	mcx_core #(.STACK_DEPTH(8)) DUT (.ref_clk, .rst, .clk_en, .instr,
		.instr_valid, .instr_ready, .pc, .pm_addr, .pm_data, .wdt_timeout,
		.wake, .wdt_restart, .power_down, .int_enable, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest);

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n > 50) begin
			fails++;
			tally_and_finish();
		end
	endtask

	// Ready is looked at on the rising edge that takes the request
	task automatic wait_rdy();
		c = 0;
		@(posedge ref_clk);
		while (instr_ready !== 1'b1) begin
			c++;
			tmo(c);
			@(posedge ref_clk);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] ad,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= ad;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			tmo(n);
			@(posedge ref_clk);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic stat();
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk("status", flg, rd[1:0]);
	endtask

	task automatic run_op(input mcx_op_t op, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] im, input logic [12:0] tg);
		logic [7:0] v, r;
		logic [12:0] np, ta;
		logic [15:0] wd;
		logic sk, tf;
		int ec;
		v = mem[a];
		np = exp_pc + 13'd1;
		ec = 1;
		sk = 1'b0;
		tf = op inside {[op_table_fetch_page:op_pointer_advance_last_page_fetch]};
		r = op inside {op_increment_skip_zero, op_increment_skip_zero_to_working}
			? v + 8'd1 : v - 8'd1;
		if (tf) begin
			if (op inside {op_pointer_advance_table_fetch,
				op_pointer_advance_last_page_fetch})
				mem[ADDR_TABLE_POINTER_REGISTER] = mem[ADDR_TABLE_POINTER_REGISTER] + 8'd1;
			ta = {mem[ADDR_TBPAGE][4:0], mem[ADDR_TABLE_POINTER_REGISTER]};
			if (op inside {op_table_fetch_last_page,
				op_pointer_advance_last_page_fetch})
				ta[12:8] = LAST_PAGE;
			wd = pm_word(ta);
			mem[a] = wd[7:0];
			mem[ADDR_TABLE_HIGH_BYTE_REGISTER] = wd[15:8];
			ec = 2;
		end
		case (op)
			op_transfer_byte_to_working: wreg = v;
			op_transfer_byte_to_memory: mem[a] = wreg;
			op_load_immediate: wreg = im;
			op_bit_clear: mem[a][b] = 1'b0;
			op_bit_set: mem[a][b] = 1'b1;
			op_unconditional_branch: np = tg;
			op_subroutine_call: begin
				stk.push_back(np);
				np = tg;
			end
			op_subroutine_exit, op_interrupt_exit: np = stk.pop_back();
			op_subroutine_exit_load: begin
				np = stk.pop_back();
				wreg = im;
			end
			op_skip_when_byte_zero: sk = v == 8'h00;
			op_skip_zero_copy_to_working: begin
				sk = v == 8'h00;
				wreg = v;
			end
			op_skip_when_nonzero: sk = v != 8'h00;
			op_skip_bit_zero: sk = !v[b];
			op_skip_bit_nonzero: sk = v[b];
			op_increment_skip_zero, op_decrement_skip_zero: begin
				mem[a] = r;
				sk = r == 8'h00;
			end
			op_increment_skip_zero_to_working,
			op_decrement_skip_zero_to_working: begin
				wreg = r;
				sk = r == 8'h00;
			end
			op_byte_clear: mem[a] = 8'h00;
			op_byte_set: mem[a] = 8'hff;
			op_nibble_exchange: mem[a] = {v[3:0], v[7:4]};
			op_nibble_exchange_to_working: wreg = {v[3:0], v[7:4]};
			op_watchdog_clear: flg = 2'b00;
			op_power_down: flg = 2'b10;
			default: ;
		endcase
		if (op inside {[op_unconditional_branch:op_interrupt_exit]})
			ec = 2;
		if (op == op_transfer_byte_to_memory && a == ADDR_PCL) begin
			np = {np[12:8], wreg};
			ec = 2;
		end
		if (sk) begin
			np = exp_pc + 13'd2;
			ec = 3;
		end
		@(posedge ref_clk);
		instr <= '{op, a, b, im, tg};
		instr_valid <= 1'b1;
		wait_rdy();
		instr_valid <= 1'b0;
		if (op == op_power_down) begin
			@(posedge ref_clk);
			chk("power_down", 1'b1, power_down);
			chk("wdt_restart", 1'b1, wdt_restart);
			wake <= 1'b1;
			@(posedge ref_clk);
			wake <= 1'b0;
			ec = 0;
		end
		wait_rdy();
		if (ec != 0)
			chk("cycles", ec, c + 1);
		if (ec == 1)
			chk("wdt_restart", op == op_watchdog_clear,
				wdt_restart);
		exp_pc = np;
		chk("pc", exp_pc, pc);
		if (tf)
			chk("pm_addr", ta, pm_addr);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		mcx_op_t op;
		logic [7:0] a, im;
		{rst, clk_en, instr_valid, wdt_timeout, wake} = 5'b11000;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		instr = '0;
		{exp_pc, wreg, flg} = '0;
		mem[ADDR_TABLE_HIGH_BYTE_REGISTER] = 8'h00;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		chk("pc", 13'h0000, pc);
		chk("ready", 1'b1, instr_ready);
		bus(1'b0, REG_CTRL, 32'h0000_0000);
		chk("ctrl", 32'h0000_0001, rd);
		bus(1'b1, 8'h18, 32'hffff_ffff);
		bus(1'b0, 8'h18, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd);
		bus(1'b1, REG_STATUS, 32'h0000_0003);
		stat();
		for (int i = 0; i < 18; i++) begin
			rd = $random(seed);
			a = i == 16 ? ADDR_TABLE_POINTER_REGISTER : i == 17 ? ADDR_TBPAGE : 8'h20 + 8'(i);
			run_op(op_load_immediate, 8'h00, 3'd0, rd[7:0], 13'h0000);
			run_op(op_transfer_byte_to_memory, a, 3'd0, 8'h00, 13'h0000);
		end
		for (int i = 0; i < 90; i++) begin
			rd = $random(seed);
			op = mcx_op_t'(rd[7:0] % 8'd30);
			if (op inside {[op_subroutine_exit:op_interrupt_exit],
				op_power_down})
				op = op_skip_bit_nonzero;
			im = rd[9:8] == 2'd0 ? 8'h00 : rd[9:8] == 2'd1 ? 8'hff : rd[31:24];
			run_op(op, {4'h2, rd[13:10]}, rd[16:14], im, rd[28:16]);
			bus(1'b0, REG_WORKING, 32'h0000_0000);
			chk("working", wreg, rd);
		end
		stat();
		run_op(op_subroutine_call, 8'h00, 3'd0, 8'h00, 13'h0123);
		run_op(op_subroutine_call, 8'h00, 3'd0, 8'h00, 13'h1456);
		run_op(op_subroutine_exit_load, 8'h00, 3'd0, 8'h3c, 13'h0000);
		run_op(op_interrupt_exit, 8'h00, 3'd0, 8'h00, 13'h0000);
		chk("int_enable", 1'b1, int_enable);
		run_op(op_load_immediate, 8'h00, 3'd0, 8'h40, 13'h0000);
		run_op(op_transfer_byte_to_memory, ADDR_PCL, 3'd0, 8'h00, 13'h0000);
		@(posedge ref_clk);
		wdt_timeout <= 1'b1;
		@(posedge ref_clk);
		wdt_timeout <= 1'b0;
		flg = 2'b01;
		stat();
		run_op(op_watchdog_clear, 8'h00, 3'd0, 8'h00, 13'h0000);
		stat();
		run_op(op_power_down, 8'h00, 3'd0, 8'h00, 13'h0000);
		stat();
		@(posedge ref_clk);
		clk_en <= 1'b0;
		repeat (4) @(posedge ref_clk);
		clk_en <= 1'b1;
		run_op(op_no_operation, 8'h00, 3'd0, 8'h00, 13'h0000);
		for (int i = 0; i < 16; i++) begin
			run_op(op_transfer_byte_to_working, 8'h20 + 8'(i), 3'd0, 8'h00,
				13'h0000);
			bus(1'b0, REG_WORKING, 32'h0000_0000);
			chk("memory", wreg, rd);
		end
		bus(1'b0, REG_TABLE_HIGH_BYTE_REGISTER, 32'h0000_0000);
		chk("table_high", mem[ADDR_TABLE_HIGH_BYTE_REGISTER], rd);
		bus(1'b0, REG_TABLE_POINTER_REGISTER, 32'h0000_0000);
		chk("table_ptr", mem[ADDR_TABLE_POINTER_REGISTER], rd);
		// Stopping the core must refuse instructions
		bus(1'b1, REG_CTRL, 32'h0000_0000);
		@(negedge ref_clk);
		chk("ready_stopped", 1'b0, instr_ready);
		chk("ie_cleared", 1'b0, int_enable);
		bus(1'b1, REG_PC, 32'h0000_1fff);
		bus(1'b0, REG_PC, 32'h0000_0000);
		chk("pc_reg", exp_pc, rd);
		bus(1'b1, REG_CTRL, 32'h0000_0001);
		bus(1'b1, REG_WORKING, 32'h0000_005a);
		bus(1'b0, REG_WORKING, 32'h0000_0000);
		chk("working_wr", 32'h0000_005a, rd);
		tally_and_finish();
	end
endmodule
